// [design/dio_top.sv]
/*
 Discrete I/O handshake: qualifies the customer inputs, drives the six status
 outputs, answers record queries and reports errors.
 Assumes process core supplies closure/pincer state, result and error numbers.
*/
`timescale 1ns/1ns
module dio_top #(
    parameter int MS_CYCLES = dio_pkg::MS_CYCLES_DEF
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               in_reset,
    input  wire logic               in_enable,
    input  wire logic               in_function,
    input  wire logic               in_start,
    input  wire logic               in_pincer_test,
    input  wire logic [6:0]         in_prog_bits,
    input  wire logic               closure_active,
    input  wire logic               pincer_test_active,
    input  wire logic               closure_done,
    input  wire logic               closure_ok,
    input  wire logic               proc_err_valid,
    input  wire logic [7:0]         proc_err_num,
    input  wire logic               query_valid,
    input  wire dio_pkg::dio_query_t query_sel,
    input  wire logic [4:0]         record_avail,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [31:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [31:0]             reg_rdata,
    output logic                    irq,
    output logic                    out_busy,
    output logic                    out_sys_err,
    output logic                    out_pincer_test,
    output logic                    out_ready,
    output logic                    out_ok,
    output logic                    out_no,
    output logic                    start_pulse,
    output logic                    abort_pulse,
    output logic                    pincer_test_req,
    output logic                    program_req,
    output logic                    routine_ack,
    output logic                    fn_display,
    output logic                    resp_valid,
    output logic [2:0]              resp_sel,
    output logic                    resp_error,
    output logic                    resp_status_no,
    output logic [7:0]              resp_err_num,
    output logic                    err_msg_valid,
    output logic [7:0]              err_msg_num,
    output logic [6:0]              program_number
);
    import dio_pkg::*;

    dio_qual_if qif[IN_N] ();
    logic [IN_N-1:0] raw_vec;
    logic [16:0]     tick_cnt;
    logic            ms_tick;
    dio_phase_t      phase;
    logic [15:0]     phase_ms;
    logic            closure_en;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic [7:0]      active_err;
    logic            start_seen;
    logic            reset_seen;
    logic            res_ok;
    logic            res_no;
    logic            run;
    logic            enable_lvl;
    logic            start_acc;
    logic            reset_acc;
    logic            fn_short;
    logic            fn_long;
    logic            can_start;
    logic            running;

    assign raw_vec = {in_pincer_test, in_start, in_function, in_enable, in_reset};

    // Start hold only accumulates while enable stays up; a drop restarts it
    for (genvar g = 0; g < IN_N; g++) begin : g_in
        assign qif[g].raw     = raw_vec[g];
        assign qif[g].ms_tick = ms_tick;
        assign qif[g].gate    = (g == IN_START) ? qif[IN_ENABLE].level : 1'b1;
        dio_qual u_qual (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .q        (qif[g])
        );
    end

    assign enable_lvl = qif[IN_ENABLE].level;
    assign run        = (phase == PH_RUN);
    assign running    = closure_active || pincer_test_active;
    assign can_start  = closure_en && enable_lvl && !running && active_err == ERR_NONE &&
                        program_number != 7'h00;
    assign start_acc  = run && !start_seen && qif[IN_START].hold_ms > START_HOLD_MS;
    assign reset_acc  = run && !reset_seen && qif[IN_RESET].hold_ms > RESET_HOLD_MS;
    // Windows around the nominal 2 s and 4 s, judged on release
    assign fn_short   = run && qif[IN_FUNC].fell && qif[IN_FUNC].hold_ms >= FN_SHORT_MS &&
                        qif[IN_FUNC].hold_ms < FN_LONG_MS;
    assign fn_long    = run && qif[IN_FUNC].fell && qif[IN_FUNC].hold_ms >= FN_LONG_MS;

    // A 1 ms tick is the only timebase; long counts stay in ms, not cycles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 17'h00000;
            ms_tick  <= 1'b0;
        end else begin
            ms_tick  <= (tick_cnt == 17'(MS_CYCLES - 1));
            tick_cnt <= (tick_cnt == 17'(MS_CYCLES - 1)) ? 17'h00000 : tick_cnt + 17'h00001;
        end
    end

    // Power-up: output test, then version display, then normal running
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase    <= PH_TEST;
            phase_ms <= 16'h0000;
        end else if (ms_tick && phase != PH_RUN) begin
            case (phase)
                PH_TEST: begin
                    phase_ms <= (phase_ms == TEST_MS) ? 16'h0000 : phase_ms + 16'h0001;
                    if (phase_ms == TEST_MS) phase <= PH_VERSION;
                end
                PH_VERSION: begin
                    phase_ms <= phase_ms + 16'h0001;
                    if (phase_ms == VERSION_MS) phase <= PH_RUN;
                end
                default: phase <= PH_RUN;
            endcase
        end
    end

    // One acceptance per press; the flag re-arms when the input drops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_seen <= 1'b0;
            reset_seen <= 1'b0;
        end else begin
            start_seen <= qif[IN_START].hold_ms != 13'h0000 && (start_seen || start_acc);
            reset_seen <= qif[IN_RESET].hold_ms != 13'h0000 && (reset_seen || reset_acc);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            program_number <= 7'h00;
        end else begin
            program_number <= dio_weight_sum(in_prog_bits);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_pulse     <= 1'b0;
            abort_pulse     <= 1'b0;
            pincer_test_req <= 1'b0;
            program_req     <= 1'b0;
            routine_ack     <= 1'b0;
            fn_display      <= 1'b0;
        end else begin
            start_pulse     <= start_acc && can_start;
            abort_pulse     <= reset_acc && running;
            pincer_test_req <= fn_short && fn_display;
            program_req     <= fn_long && fn_display;
            routine_ack     <= fn_long && !fn_display;
            if (run && qif[IN_PTEST].rose) begin
                fn_display <= 1'b1;
            end else if ((fn_short || fn_long) && fn_display) begin
                fn_display <= 1'b0;
            end
        end
    end

    // Error source order: reset cancel, missing program, process core
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            err_msg_valid <= 1'b0;
            err_msg_num   <= ERR_NONE;
            active_err    <= ERR_NONE;
        end else begin
            err_msg_valid <= 1'b0;
            if (reset_acc && running) begin
                err_msg_valid <= 1'b1;
                err_msg_num   <= ERR_RESET_CANCEL;
                active_err    <= ERR_RESET_CANCEL;
            end else if (start_acc && program_number == 7'h00) begin
                err_msg_valid <= 1'b1;
                err_msg_num   <= ERR_NO_APN;
                active_err    <= ERR_NO_APN;
            end else if (proc_err_valid) begin
                err_msg_valid <= 1'b1;
                err_msg_num   <= proc_err_num;
                active_err    <= proc_err_num;
            end else if (reset_acc) begin
                active_err    <= ERR_NONE;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resp_valid     <= 1'b0;
            resp_sel       <= 3'h0;
            resp_error     <= 1'b0;
            resp_status_no <= 1'b0;
            resp_err_num   <= ERR_NONE;
        end else begin
            resp_valid <= query_valid;
            if (query_valid) begin
                resp_sel       <= query_sel;
                resp_error     <= ~record_avail[query_sel];
                resp_status_no <= ~record_avail[query_sel];
                resp_err_num   <= record_avail[query_sel] ? ERR_NONE : ERR_NO_DATA;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            res_ok <= 1'b0;
            res_no <= 1'b0;
        end else if (start_acc && can_start) begin
            res_ok <= 1'b0;
            res_no <= 1'b0;
        end else if (closure_done) begin
            res_ok <= closure_ok;
            res_no <= ~closure_ok;
        end
    end

    // Output matrix, registered so every pin comes from a flop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_busy        <= 1'b1;
            out_sys_err     <= 1'b1;
            out_pincer_test <= 1'b1;
            out_ready       <= 1'b1;
            out_ok          <= 1'b1;
            out_no          <= 1'b1;
        end else begin
            case (phase)
                PH_TEST: begin
                    {out_busy, out_sys_err, out_pincer_test} <= 3'h7;
                    {out_ready, out_ok, out_no}              <= 3'h7;
                end
                PH_VERSION: begin
                    {out_busy, out_sys_err, out_pincer_test} <= 3'h4;
                    {out_ready, out_ok, out_no}              <= 3'h0;
                end
                default: begin
                    out_busy        <= closure_active;
                    out_sys_err     <= dio_is_sys_err(active_err);
                    out_pincer_test <= pincer_test_active;
                    out_ready       <= can_start;
                    out_ok          <= res_ok;
                    out_no          <= res_no;
                end
            endcase
        end
    end

    // Register slave; status bits are write-one-to-clear and a new event wins
    assign irq_set = {query_valid, err_msg_valid, program_req, pincer_test_req,
                      abort_pulse, start_pulse};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            closure_en <= 1'b0;
            irq_mask   <= '0;
            irq_stat   <= '0;
        end else begin
            if (reg_wr && reg_addr == REG_CTRL) closure_en <= reg_wdata[0];
            if (reg_wr && reg_addr == REG_IRQ_MASK) irq_mask <= reg_wdata[IRQ_W-1:0];
            irq_stat <= (irq_stat & ~((reg_wr && reg_addr == REG_IRQ_STAT) ?
                        reg_wdata[IRQ_W-1:0] : '0)) | irq_set;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq       <= 1'b0;
            reg_rdata <= 32'h00000000;
        end else begin
            irq       <= |(irq_stat & irq_mask);
            reg_rdata <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    REG_CTRL:     reg_rdata <= {31'h0, closure_en};
                    REG_STATUS:   reg_rdata <= {23'h0, phase, fn_display, can_start,
                                                qif[IN_PTEST].level, qif[IN_START].level,
                                                qif[IN_FUNC].level, enable_lvl, qif[IN_RESET].level};
                    REG_IRQ_STAT: reg_rdata <= {26'h0, irq_stat};
                    REG_IRQ_MASK: reg_rdata <= {26'h0, irq_mask};
                    REG_PROG:     reg_rdata <= {25'h0, program_number};
                    REG_ERR:      reg_rdata <= {24'h0, active_err};
                    default:      reg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    property p_test_all;
        @(posedge core_clk) disable iff (!rst_n)
        phase == PH_TEST |=> out_busy && out_sys_err && out_pincer_test && out_ready && out_ok && out_no;
    endproperty
    a_test_all: assert property (p_test_all) else $error("output test not all high");

    property p_version;
        @(posedge core_clk) disable iff (!rst_n)
        phase == PH_VERSION |=> out_busy && !out_sys_err && !out_pincer_test && !out_ready && !out_ok && !out_no;
    endproperty
    a_version: assert property (p_version) else $error("version phase outputs wrong");

    property p_busy;
        @(posedge core_clk) disable iff (!rst_n)
        run && closure_active |=> out_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("busy low during closure");

    property p_sys_err;
        @(posedge core_clk) disable iff (!rst_n)
        run ##1 run |-> out_sys_err == dio_is_sys_err($past(active_err));
    endproperty
    a_sys_err: assert property (p_sys_err) else $error("system error mismatch");

    property p_ok_no;
        @(posedge core_clk) disable iff (!rst_n)
        phase == PH_RUN |=> !(out_ok && out_no);
    endproperty
    a_ok_no: assert property (p_ok_no) else $error("OK and NO together");

    property p_ready;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(out_ready) && $past(run) |-> $past(closure_en && enable_lvl && !running);
    endproperty
    a_ready: assert property (p_ready) else $error("ready without start condition");

    property p_start;
        @(posedge core_clk) disable iff (!rst_n)
        start_pulse |-> $past(qif[IN_START].hold_ms) > START_HOLD_MS && $past(enable_lvl);
    endproperty
    a_start: assert property (p_start) else $error("start taken too early");

    property p_no_data;
        @(posedge core_clk) disable iff (!rst_n)
        query_valid && !record_avail[query_sel] |=> resp_valid && resp_error && resp_status_no &&
                                                   resp_err_num == ERR_NO_DATA;
    endproperty
    a_no_data: assert property (p_no_data) else $error("missing record reply wrong");

    property p_reset_cancel;
        @(posedge core_clk) disable iff (!rst_n)
        reset_acc && running |=> abort_pulse && err_msg_valid && err_msg_num == ERR_RESET_CANCEL;
    endproperty
    a_reset_cancel: assert property (p_reset_cancel) else $error("reset did not cancel");

    property p_no_apn;
        @(posedge core_clk) disable iff (!rst_n)
        start_acc && program_number == 7'h00 && !(reset_acc && running) |=> err_msg_valid &&
            err_msg_num == ERR_NO_APN && !start_pulse;
    endproperty
    a_no_apn: assert property (p_no_apn) else $error("missing program not reported");

    property p_prog;
        @(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> program_number == dio_weight_sum($past(in_prog_bits));
    endproperty
    a_prog: assert property (p_prog) else $error("program number wrong");

    c_start: cover property (@(posedge core_clk) disable iff (!rst_n) start_pulse);
    c_abort: cover property (@(posedge core_clk) disable iff (!rst_n) abort_pulse);
    c_ptreq: cover property (@(posedge core_clk) disable iff (!rst_n) pincer_test_req);
    c_query: cover property (@(posedge core_clk) disable iff (!rst_n) resp_valid && !resp_error);
endmodule : dio_top

// [design/dio_pkg.sv]
/*
 Constants, types and helpers shared by the discrete I/O handshake block.
 Assumes a 100 MHz core clock; all hold times are counted in 1 ms ticks.
*/
// Functional notes
// - Five query commands each return one record.
// - Query without record answers C, 99, NO.
// - Errors send numbered message; 8 means no program.
// - Reset held over 300 ms aborts, raises cancel.
// - Start ignored unless enable held continuously.
// - Start counts only when held over 100 ms.
// - Function hold: 2 s pincer test, 4 s program.
// - Pincer test input returns to function display.
// - Program number is weighted sum of seven bits.
// - Busy during startup and during closure.
// - System error only for the listed errors.
// - Ready only when closure can be started.
// - Output test drives all six outputs high.
// - Version display drives busy only.
package dio_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES_DEF = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int          HOLD_W         = 13;
    localparam logic [12:0] START_HOLD_MS  = 13'h0064;
    localparam logic [12:0] RESET_HOLD_MS  = 13'h012C;
    localparam logic [12:0] FN_SHORT_MS    = 13'h05DC;
    localparam logic [12:0] FN_LONG_MS     = 13'h0BB8;
    localparam logic [12:0] HOLD_SAT       = 13'h1FFF;
    localparam logic [3:0]  DEBOUNCE_MS    = 4'h5;
    localparam logic [15:0] TEST_MS        = 16'h03E8;
    localparam logic [15:0] VERSION_MS     = 16'h07D0;

    localparam int IN_RESET  = 0;
    localparam int IN_ENABLE = 1;
    localparam int IN_FUNC   = 2;
    localparam int IN_START  = 3;
    localparam int IN_PTEST  = 4;
    localparam int IN_N      = 5;

    localparam logic [7:0] ERR_NO_APN       = 8'h08;
    localparam logic [7:0] ERR_RESET_CANCEL = 8'h13;
    localparam logic [7:0] ERR_NO_DATA      = 8'h63;
    localparam logic [7:0] ERR_NONE         = 8'h00;

    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
    localparam logic [7:0] REG_PROG     = 8'h10;
    localparam logic [7:0] REG_ERR      = 8'h14;

    localparam int IRQ_W       = 6;
    localparam int IRQ_START   = 0;
    localparam int IRQ_RCANCEL = 1;
    localparam int IRQ_PTREQ   = 2;
    localparam int IRQ_PROGREQ = 3;
    localparam int IRQ_ERR     = 4;
    localparam int IRQ_QUERY   = 5;

    typedef enum logic [2:0] {Q_HOLDER, Q_DETECT, Q_CONTACT, Q_CLOSURE, Q_VERIFY} dio_query_t;
    typedef enum logic [1:0] {PH_TEST, PH_VERSION, PH_RUN} dio_phase_t;

    function automatic logic dio_is_sys_err(input logic [7:0] num);
        dio_is_sys_err = (num >= 8'h01 && num <= 8'h03) || num == 8'h08 || num == 8'h0F ||
                         num == 8'h10 || (num >= 8'h13 && num <= 8'h15) || num == 8'h17;
    endfunction : dio_is_sys_err

    function automatic logic [6:0] dio_weight_sum(input logic [6:0] bits);
        logic [6:0] acc;
        acc = 7'h00;
        for (int i = 0; i < 7; i++) begin
            if (bits[i]) acc = acc + 7'(1 << i);
        end
        dio_weight_sum = acc;
    endfunction : dio_weight_sum
endpackage : dio_pkg

// [design/dio_qual_if.sv]
/*
 Carrier between the top block and one input qualifier.
 Assumes the ms tick is a one-cycle pulse from the top block.
*/
`timescale 1ns/1ns
interface dio_qual_if;
    logic        ms_tick;
    logic        gate;
    logic        raw;
    logic        level;
    logic        rose;
    logic        fell;
    logic [12:0] hold_ms;
    modport qual (input ms_tick, input gate, input raw, output level, output rose, output fell, output hold_ms);
    modport user (output ms_tick, output gate, output raw, input level, input rose, input fell, input hold_ms);
endinterface : dio_qual_if

// [design/dio_qual.sv]
/*
 One discrete input: two-flop synchroniser, ms debounce, hold-time counter.
 Assumes the input is slow against the 1 ms tick; the counter clears while gate is low.
*/
`timescale 1ns/1ns
module dio_qual (
    input wire logic   core_clk,
    input wire logic   rst_n,
    dio_qual_if.qual   q
);
    import dio_pkg::*;
    logic       sync1;
    logic       sync2;
    logic [3:0] deb_cnt;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end else begin
            sync1 <= q.raw;
            sync2 <= sync1;
        end
    end

    // Level only moves after the synced value held steady for the debounce time
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            deb_cnt <= 4'h0;
            q.level <= 1'b0;
            q.rose  <= 1'b0;
            q.fell  <= 1'b0;
        end else begin
            q.rose <= 1'b0;
            q.fell <= 1'b0;
            if (sync2 == q.level) begin
                deb_cnt <= 4'h0;
            end else if (q.ms_tick) begin
                if (deb_cnt == DEBOUNCE_MS) begin
                    deb_cnt <= 4'h0;
                    q.level <= sync2;
                    q.rose  <= sync2;
                    q.fell  <= ~sync2;
                end else begin
                    deb_cnt <= deb_cnt + 4'h1;
                end
            end
        end
    end

    // Hold value survives the fall cycle so the user can judge the length
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q.hold_ms <= 13'h0000;
        end else if (!q.level || !q.gate) begin
            q.hold_ms <= 13'h0000;
        end else if (q.ms_tick && q.hold_ms != HOLD_SAT) begin
            q.hold_ms <= q.hold_ms + 13'h0001;
        end
    end
endmodule : dio_qual

// [tb/dio_host_model.sv]
/* Customer controller model driving the discrete lines.
   Assumes core_clk and MSC cycles to one ms. */
`timescale 1ns/1ns
module dio_host_model #(parameter int MSC = 10) (
    input  wire logic core_clk,
    output logic [4:0] lines,
    output logic [6:0] prog_bits
);
    initial begin
        lines = 5'h00;
        prog_bits = 7'h00;
    end
    // Enable is held steady between calls
    task automatic set_line(input int i, input logic v);
        @(posedge core_clk);
        lines[i] <= v;
    endtask : set_line
    task automatic set_prog(input logic [6:0] v);
        @(posedge core_clk);
        prog_bits <= v;
    endtask : set_prog
    task automatic press(input int i, input int ms);
        @(posedge core_clk);
        lines[i] <= 1'b1;
        repeat (ms * MSC) @(posedge core_clk);
        lines[i] <= 1'b0;
    endtask : press
endmodule : dio_host_model

// [tb/dio_top_tb_top.sv]
/* Bench for the discrete I/O block: register tasks and call sequences.
   Assumes MS_CYCLES scaled to 10 so one ms is ten clocks. */
`timescale 1ns/1ns
module dio_top_tb_top;
    import dio_pkg::*;
    localparam int MSC = 10;
    logic core_clk, rst_n, closure_active, pincer_test_active, closure_done, closure_ok;
    logic proc_err_valid, query_valid, reg_wr, reg_rd, irq, fn_display, resp_valid, resp_error, resp_status_no;
    logic out_busy, out_sys_err, out_pincer_test, out_ready, out_ok, out_no;
    logic [2:0] resp_sel;
    logic [4:0] record_avail, lines;
    logic [6:0] prog_bits, program_number;
    logic [7:0] proc_err_num, reg_addr, resp_err_num, err_msg_num;
    logic [31:0] reg_wdata, reg_rdata;
    dio_query_t query_sel;
    int mismatches, checks_done, cycles;
    logic [8:0] errs [6] = '{9'h101, 9'h004, 9'h10F, 9'h011, 9'h016, 9'h117};
    dio_top #(.MS_CYCLES(MSC)) i_dut (.core_clk, .rst_n, .in_reset(lines[IN_RESET]),
        .in_enable(lines[IN_ENABLE]), .in_function(lines[IN_FUNC]), .in_start(lines[IN_START]),
        .in_pincer_test(lines[IN_PTEST]), .in_prog_bits(prog_bits), .closure_active, .pincer_test_active,
        .closure_done, .closure_ok, .proc_err_valid, .proc_err_num, .query_valid, .query_sel, .record_avail,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .out_busy, .out_sys_err, .out_pincer_test,
        .out_ready, .out_ok, .out_no, .start_pulse(), .abort_pulse(), .pincer_test_req(), .program_req(),
        .routine_ack(), .fn_display, .resp_valid, .resp_sel, .resp_error, .resp_status_no, .resp_err_num,
        .err_msg_valid(), .err_msg_num, .program_number);
    dio_host_model #(.MSC(MSC)) i_host (.core_clk, .lines, .prog_bits);
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 80000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic ms(input int n);
        repeat (n * MSC) @(posedge core_clk);
    endtask : ms
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(nm, e, reg_rdata);
    endtask : rd
    task automatic report_and_stop();
        if (mismatches == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        {core_clk, rst_n, closure_active, pincer_test_active, closure_done, closure_ok, proc_err_valid,
         query_valid, reg_wr, reg_rd, record_avail, proc_err_num, reg_addr, reg_wdata} = '0;
        query_sel = Q_HOLDER;
        repeat (10) @(posedge core_clk);
        chk("outs", 6'h3F, {out_busy, out_sys_err, out_pincer_test, out_ready, out_ok, out_no});
        rst_n <= 1'b1;
        ms(1500);
        chk("outs", 6'h20, {out_busy, out_sys_err, out_pincer_test, out_ready, out_ok, out_no});
        ms(1600);
        rd(REG_STATUS, 32'h100, "status");
        wr(REG_IRQ_MASK, 32'h3F);
        rd(8'h40, 32'h0, "unmapped");
        record_avail <= 5'h15;
        for (int q = 0; q < 5; q++) begin
            @(posedge core_clk);
            query_valid <= 1'b1;
            query_sel <= dio_query_t'(q);
            @(posedge core_clk);
            query_valid <= 1'b0;
            #1 chk("resp", q % 2 ? 32'h763 : 32'h10 | q, q % 2 ? {resp_valid, resp_status_no, resp_error,
                resp_err_num} : {resp_valid, resp_error, resp_sel});
        end
        rd(REG_IRQ_STAT, 32'h20, "irq_stat");
        chk("irq", 1, irq);
        wr(REG_IRQ_STAT, 32'h3F);
        @(posedge core_clk);
        #1 chk("irq", 0, irq);
        wr(REG_CTRL, 32'h1);
        i_host.set_line(IN_ENABLE, 1);
        i_host.press(IN_START, 115);
        ms(10);
        rd(REG_IRQ_STAT, 32'h10, "no_prog");
        chk("err_num", 8'h08, err_msg_num);
        foreach (errs[i]) begin
            @(posedge core_clk);
            proc_err_valid <= 1'b1;
            proc_err_num <= errs[i][7:0];
            @(posedge core_clk);
            proc_err_valid <= 1'b0;
            repeat (3) @(posedge core_clk);
            chk("sys_err", errs[i][8], out_sys_err);
        end
        i_host.press(IN_RESET, 320);
        i_host.set_prog(7'h28);
        ms(10);
        chk("sys_err", 0, out_sys_err);
        rd(REG_PROG, 32'h28, "prog");
        chk("ready", 1, out_ready);
        i_host.set_line(IN_ENABLE, 0);
        ms(10);
        chk("ready", 0, out_ready);
        i_host.press(IN_START, 115);
        i_host.set_line(IN_ENABLE, 1);
        i_host.press(IN_START, 60);
        ms(10);
        wr(REG_IRQ_STAT, 32'h3F);
        rd(REG_IRQ_STAT, 32'h0, "no_start");
        i_host.press(IN_START, 115);
        ms(10);
        rd(REG_IRQ_STAT, 32'h1, "start");
        closure_active <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("busy_ready", 2'b10, {out_busy, out_ready});
        closure_done <= 1'b1;
        @(posedge core_clk);
        closure_done <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("ok_no", 2'b01, {out_ok, out_no});
        i_host.press(IN_RESET, 320);
        ms(10);
        chk("abort", 9'h113, {out_sys_err, err_msg_num});
        rd(REG_IRQ_STAT, 32'h13, "abort");
        pincer_test_active <= 1'b1;
        i_host.press(IN_PTEST, 20);
        ms(10);
        chk("ptest_fn", 2'b11, {out_pincer_test, fn_display});
        i_host.press(IN_FUNC, 2000);
        ms(10);
        rd(REG_IRQ_STAT, 32'h17, "ptreq");
        chk("fn_exit", 0, fn_display);
        report_and_stop();
    end
endmodule : dio_top_tb_top
